/* File: bench/cpa_copro_model.sv */
/* coprocessor stand-in driving both handshake buses.
   assumes the bench raises claim while it wants the op held. */
`timescale 1ns/1ps
module cpa_copro_model
    import cpa_pkg::*;
(
    input  wire logic       clk,      // core clock
    input  wire logic       rst,      // sync reset
    input  wire logic       claim,    // hold op in wait
    input  wire logic [1:0] end_code, // execute answer on release
    output logic [1:0]      hs_dec,   // decode response
    output logic [1:0]      hs_exe    // execute response
);
    // absent is the resting decode answer, so an unclaimed op always traps
    always_ff @(posedge clk) begin
        if (rst) begin
            hs_dec <= CPA_HS_ABSENT;
            hs_exe <= CPA_HS_ABSENT;
        end else begin
            hs_dec <= claim ? CPA_HS_WAIT : CPA_HS_ABSENT;
            hs_exe <= claim ? CPA_HS_WAIT : end_code;
        end
    end
endmodule : cpa_copro_model

/* File: bench/cpa_seq_asserts.sv */
/* port checker for the sequencer.
   assumes one clock and sync high reset; bound into cpa_seq. */
`timescale 1ns/1ps
module cpa_seq_asserts (
    input wire logic        clk,               // clock
    input wire logic        rst,               // reset
    input wire logic        fetched_word_valid,       // issue
    input wire logic        fetched_word_is_cp,       // cp op
    input wire logic        cond_pass,         // cond met
    input wire logic [31:0] pc_in,             // pc
    input wire logic [31:0] fetch_addr,        // fetch addr
    input wire logic        fetch_req_n,       // fetch req
    input wire logic        fetch_sequential,  // seq
    input wire logic        load_store_req_n,  // data req
    input wire logic        pass_flag,         // pass
    input wire logic        late_abandon_flag, // late
    input wire logic        seq_busy,          // busy
    input wire logic        undef_taken        // trap
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic issue;
    assign issue = fetched_word_valid && !seq_busy;

    a_late_low: assert property (!late_abandon_flag) else $error("late abandon raised");
    a_data_idle: assert property (load_store_req_n) else $error("data side active");
    a_undef_vec: assert property (undef_taken |-> fetch_addr == 32'h0000_0004
        && !fetch_req_n && !fetch_sequential && !pass_flag) else $error("bad trap fetch");
    a_vec_walk: assert property (undef_taken |=> fetch_addr == 32'h0000_0008 && fetch_sequential
        && !fetch_req_n ##1 fetch_addr == 32'h0000_000C && fetch_sequential && !pass_flag)
        else $error("bad vector walk");
    a_idle_before: assert property ($rose(undef_taken) |-> $past(fetch_req_n))
        else $error("no idle cycle before trap");
    a_skip_one: assert property (issue && !cond_pass |=> !fetch_req_n && fetch_sequential
        && fetch_addr == $past(pc_in) && !pass_flag && !seq_busy) else $error("bad skipped cycle");
    a_cp_first: assert property (issue && fetched_word_is_cp && cond_pass |=> pass_flag && fetch_req_n)
        else $error("bad first cp cycle");
    a_pass_once: assert property (seq_busy && pass_flag |=> !pass_flag) else $error("pass held");

    c_trap: cover property (undef_taken);
    c_skip: cover property (issue && !cond_pass);
    c_long_wait: cover property (seq_busy [*5]);
endmodule : cpa_seq_asserts

bind cpa_seq cpa_seq_asserts i_chk (.clk, .rst, .fetched_word_valid, .fetched_word_is_cp, .cond_pass, .pc_in,
    .fetch_addr, .fetch_req_n, .fetch_sequential, .load_store_req_n, .pass_flag, .late_abandon_flag,
    .seq_busy, .undef_taken);

/* File: bench/tb_coproc_absent_trap_timing.sv */
/* self-checking bench for the coprocessor-absent sequencer.
   assumes cpa_seq, the coprocessor model and the bound checker. */
`timescale 1ns/1ps
module tb_coproc_absent_trap_timing import cpa_pkg::*;;
    logic        clk = 1'b0, rst = 1'b1, fetched_word_valid = 1'b0, fetched_word_is_cp = 1'b0, cond_pass = 1'b0;
    logic        claim = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [1:0]  end_code = CPA_HS_ABSENT;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] pc_in = 32'h0, fetched_word = 32'h0, s_axi_wdata = 32'h0;
    logic        fetch_req_n, fetch_sequential, load_store_req_n, load_store_sequential, pass_flag;
    logic        late_abandon_flag, seq_busy, undef_taken, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  cp_handshake_decode, cp_handshake_execute, s_axi_bresp, s_axi_rresp;
    logic [31:0] fetch_addr, load_store_addr, s_axi_rdata;
    int          n_fail = 0, checked = 0, cycles = 0;

    cpa_seq i_dut (.*);
    cpa_copro_model i_cp (.clk(clk), .rst(rst), .claim(claim), .end_code(end_code),
        .hs_dec(cp_handshake_decode), .hs_exe(cp_handshake_execute));

    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (n_fail == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic drv(input logic cp, input logic cc, input logic [31:0] pc);
        fetched_word_valid  <= 1'b1;
        fetched_word_is_cp  <= cp;
        cond_pass    <= cc;
        pc_in        <= pc;
        fetched_word <= 32'hE000_0000 | pc;
    endtask : drv

    // ends at the falling edge of the first cycle after the taking edge
    task automatic issue(input logic cp, input logic [31:0] pc);
        @(posedge clk);
        drv(cp, 1'b1, pc);
        @(posedge clk);
        fetched_word_valid <= 1'b0;
        @(negedge clk);
    endtask : issue

    // handshake passes the synchroniser and its agreement filter, so give it time to land
    task automatic claim_set(input logic v);
        @(posedge clk);
        claim <= v;
        repeat (6) @(posedge clk);
    endtask : claim_set

    task automatic icyc(input logic ps);
        chk(fetch_req_n === 1'b1 && pass_flag === ps && load_store_req_n === 1'b1
            && load_store_sequential === 1'b0 && late_abandon_flag === 1'b0, "idle cycle");
    endtask : icyc

    task automatic vec_chk();
        for (int i = 0; i < 3; i++) begin
            chk(fetch_addr === CPA_UNDEF_VEC + CPA_WORD_STEP * i && fetch_req_n === 1'b0
                && fetch_sequential === (i != 0) && pass_flag === 1'b0 && undef_taken === (i == 0)
                && load_store_req_n === 1'b1 && late_abandon_flag === 1'b0
                && load_store_sequential === 1'b0 && load_store_addr === 32'h0000_0000, "vector fetch");
            @(negedge clk);
        end
    endtask : vec_chk

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ra, rw, rb;
        logic [1:0] rs;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(negedge clk);
            ra = s_axi_awready;
            rw = s_axi_wready;
            rb = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge clk);
            if (ra) s_axi_awvalid <= 1'b0;
            if (rw) s_axi_wvalid <= 1'b0;
        end while (!rb);
        s_axi_bready <= 1'b0;
        chk(rs === er, "write response");
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed);
        logic ra, rv;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(negedge clk);
            ra = s_axi_arready;
            rv = s_axi_rvalid;
            if (rv) chk(s_axi_rdata === ed && s_axi_rresp === CPA_RESP_OKAY, "read data");
            @(posedge clk);
            if (ra) s_axi_arvalid <= 1'b0;
        end while (!rv);
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        axi_rd(CPA_OFS_CTRL, CPA_CTRL_RESET);
        // two skipped instructions taken on adjacent edges
        @(posedge clk);
        drv(1'b0, 1'b0, 32'h0000_0100);
        @(posedge clk);
        drv(1'b0, 1'b0, 32'h0000_0104);
        @(negedge clk);
        chk(fetch_addr === 32'h0000_0100 && fetch_req_n === 1'b0 && fetch_sequential === 1'b1, "skip one");
        @(posedge clk);
        fetched_word_valid <= 1'b0;
        @(negedge clk);
        chk(fetch_addr === 32'h0000_0104 && pass_flag === 1'b0 && seq_busy === 1'b0, "skip two");
        issue(1'b1, 32'h0000_0200);
        chk(fetch_addr === 32'h0000_0200 && fetch_req_n === 1'b1 && pass_flag === 1'b1, "decode absent");
        @(negedge clk);
        vec_chk();
        claim_set(1'b1);
        issue(1'b1, 32'h0000_0300);
        icyc(1'b1);
        repeat (3) begin
            @(negedge clk);
            icyc(1'b0);
        end
        axi_rd(CPA_OFS_STATUS, {26'h000_0000, CPA_HS_WAIT, CPA_HS_WAIT, 2'h2});
        @(posedge clk);
        claim <= 1'b0;
        for (int k = 0; k < 12 && undef_taken !== 1'b1; k++) begin
            @(negedge clk);
            if (undef_taken !== 1'b1) icyc(1'b0);
        end
        vec_chk();
        // go and last both release the wait without a trap
        for (int e = 0; e < 2; e++) begin
            @(posedge clk);
            end_code <= (e == 0) ? CPA_HS_GO : CPA_HS_LAST;
            claim_set(1'b1);
            issue(1'b1, 32'h0000_0400);
            @(posedge clk);
            claim <= 1'b0;
            for (int k = 0; k < 12 && seq_busy !== 1'b0; k++) begin
                @(negedge clk);
                chk(undef_taken === 1'b0, "trap on go");
            end
            chk(seq_busy === 1'b0, "go wait stuck");
        end
        @(posedge clk);
        end_code <= CPA_HS_ABSENT;
        issue(1'b0, 32'h0000_0600);
        chk(fetch_addr === 32'h0000_0600 && fetch_req_n === 1'b0 && fetch_sequential === 1'b1
            && seq_busy === 1'b0 && undef_taken === 1'b0, "plain issue");
        // a willing coprocessor is bypassed outside 32-bit state
        axi_wr(CPA_OFS_CTRL, 32'h0000_0000, CPA_RESP_OKAY);
        claim_set(1'b1);
        issue(1'b1, 32'h0000_0500);
        @(negedge clk);
        vec_chk();
        claim_set(1'b0);
        axi_rd(CPA_OFS_COUNT, 32'h0002_0003);
        axi_rd(CPA_OFS_PC, 32'hE000_0500);
        axi_wr(CPA_OFS_STATUS, 32'hFFFF_FFFF, CPA_RESP_SLVERR);
        axi_wr(CPA_OFS_CTRL, 32'h0000_0003, CPA_RESP_OKAY);
        axi_rd(CPA_OFS_COUNT, 32'h0000_0000);
        axi_rd(CPA_OFS_CTRL, CPA_CTRL_RESET);
        complete_run();
    end
endmodule : tb_coproc_absent_trap_timing

/* File: rtl/cpa_pkg.sv */
/*
 * Package for the coprocessor-absent and condition-failed sequencer:
 * handshake codes, vector addresses, register map and reset values.
 * Assumes a single core clock and AXI4-Lite register access.
 */
package cpa_pkg;
    // handshake codes shared with the coprocessor
    localparam logic [1:0] CPA_HS_ABSENT = 2'h0;
    localparam logic [1:0] CPA_HS_WAIT   = 2'h1;
    localparam logic [1:0] CPA_HS_GO     = 2'h2;
    localparam logic [1:0] CPA_HS_LAST   = 2'h3;

    localparam logic [31:0] CPA_UNDEF_VEC = 32'h0000_0004;
    localparam logic [31:0] CPA_WORD_STEP = 32'h0000_0004;
    localparam logic [31:0] CPA_PC_RESET  = 32'h0000_0000;

    // register byte offsets
    localparam logic [3:0] CPA_OFS_CTRL   = 4'h0;
    localparam logic [3:0] CPA_OFS_STATUS = 4'h4;
    localparam logic [3:0] CPA_OFS_COUNT  = 4'h8;
    localparam logic [3:0] CPA_OFS_PC     = 4'hC;

    // control field positions
    localparam int CPA_CTRL_WIDE_BIT   = 0;
    localparam int CPA_CTRL_CLRCNT_BIT = 1;
    localparam logic [31:0] CPA_CTRL_RESET = 32'h0000_0001;

    localparam logic [1:0] CPA_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CPA_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        CPA_IDLE,
        CPA_ABS_DEC,
        CPA_EXE_WAIT,
        CPA_VEC0,
        CPA_VEC1,
        CPA_VEC2
    } cpa_state_t;
endpackage : cpa_pkg

/* File: rtl/cpa_seq.sv */
/*
 * Core-side sequencer for coprocessor instructions that nobody accepts and
 * for instructions whose condition fails, with an AXI4-Lite register file.
 * Assumes the instruction issue strobes come from core logic on clk, and the
 * coprocessor handshake arrives from another block and is synchronised here.
 */
`timescale 1ns/1ps

// Summary of operation
// - unaccepted coprocessor instruction takes the undefined-instruction path to vector 0x4
// - coprocessor instructions issue only in 32-bit state; otherwise treated undefined
// - decode absent: one idle cycle pass high, then fetch 0x4, 0x8, 0xC pass low
// - execute absent: idle while wait, pass only first cycle, then fetch vectors
// - late abandon low and load/store side idle through both absent sequences
// - condition-failed instruction is not executed and takes exactly one cycle
// - condition-failed cycle fetches sequentially at pc+3i, load/store idle
module cpa_seq
    import cpa_pkg::*;
(
    input  wire logic        clk,                    // core clock
    input  wire logic        rst,                    // sync reset, high
    input  wire logic        fetched_word_valid,            // instruction enters execute
    input  wire logic        fetched_word_is_cp,            // it is a coprocessor op
    input  wire logic        cond_pass,              // its condition is met
    input  wire logic [31:0] pc_in,                  // current fetch address pc+3i
    input  wire logic [1:0]  cp_handshake_decode,    // coprocessor decode response
    input  wire logic [1:0]  cp_handshake_execute,   // coprocessor execute response
    input  wire logic [31:0] fetched_word,           // instruction bus data
    output logic [31:0]      fetch_addr,             // instruction address
    output logic             fetch_req_n,            // fetch request, low active
    output logic             fetch_sequential,       // sequential fetch
    output logic             load_store_req_n,       // data request, low active
    output logic             load_store_sequential,  // data sequential
    output logic [31:0]      load_store_addr,        // data address
    output logic             pass_flag,              // condition passed
    output logic             late_abandon_flag,      // late cancel
    output logic             seq_busy,               // sequencer holds issue
    output logic             undef_taken,            // one-cycle undefined entry
    input  wire logic [3:0]  s_axi_awaddr,           // write address
    input  wire logic        s_axi_awvalid,          // write address valid
    output logic             s_axi_awready,          // write address ready
    input  wire logic [31:0] s_axi_wdata,            // write data
    input  wire logic [3:0]  s_axi_wstrb,            // write strobes
    input  wire logic        s_axi_wvalid,           // write data valid
    output logic             s_axi_wready,           // write data ready
    output logic [1:0]       s_axi_bresp,            // write response
    output logic             s_axi_bvalid,           // write response valid
    input  wire logic        s_axi_bready,           // write response ready
    input  wire logic [3:0]  s_axi_araddr,           // read address
    input  wire logic        s_axi_arvalid,          // read address valid
    output logic             s_axi_arready,          // read address ready
    output logic [31:0]      s_axi_rdata,            // read data
    output logic [1:0]       s_axi_rresp,            // read response
    output logic             s_axi_rvalid,           // read valid
    input  wire logic        s_axi_rready            // read ready
);
    cpa_state_t  state_reg, state_next;
    logic [1:0]  hsd_s1_reg, hsd_reg, hse_s1_reg, hse_reg;
    logic [1:0]  hsd_prev_reg, hse_prev_reg, hsd_code_reg, hse_code_reg;
    logic [31:0] addr_reg, addr_next;
    logic        nreq_reg, nreq_next;
    logic        seq_reg, seq_next;
    logic        pass_reg, pass_next;
    logic        undef_reg;
    logic [31:0] ctrl_reg;
    logic [15:0] undef_cnt_reg, skip_cnt_reg;
    logic [31:0] last_word_reg;

    // handshakes come from another block; synchronise before use
    always_ff @(posedge clk) begin
        if (rst) begin
            hsd_s1_reg <= CPA_HS_ABSENT;
            hsd_reg    <= CPA_HS_ABSENT;
            hse_s1_reg <= CPA_HS_ABSENT;
            hse_reg    <= CPA_HS_ABSENT;
        end else begin
            hsd_s1_reg <= cp_handshake_decode;
            hsd_reg    <= hsd_s1_reg;
            hse_s1_reg <= cp_handshake_execute;
            hse_reg    <= hse_s1_reg;
        end
    end

    // a two-bit code can tear in the synchroniser (wait to go flips both bits);
    // a code is believed only once it reads the same on two edges in a row
    always_ff @(posedge clk) begin
        if (rst) begin
            hsd_prev_reg <= CPA_HS_ABSENT;
            hse_prev_reg <= CPA_HS_ABSENT;
            hsd_code_reg <= CPA_HS_ABSENT;
            hse_code_reg <= CPA_HS_ABSENT;
        end else begin
            hsd_prev_reg <= hsd_reg;
            hse_prev_reg <= hse_reg;
            if (hsd_reg == hsd_prev_reg) begin
                hsd_code_reg <= hsd_reg;
            end
            if (hse_reg == hse_prev_reg) begin
                hse_code_reg <= hse_reg;
            end
        end
    end

    wire wide_state  = ctrl_reg[CPA_CTRL_WIDE_BIT];
    wire issue       = fetched_word_valid && (state_reg == CPA_IDLE);
    wire cp_issue    = issue && cond_pass && fetched_word_is_cp;
    // outside 32-bit state a coprocessor op never reaches the coprocessor
    wire cp_undef    = cp_issue && !wide_state;
    wire dec_absent  = cp_issue && wide_state && (hsd_code_reg == CPA_HS_ABSENT);
    wire dec_wait    = cp_issue && wide_state && (hsd_code_reg == CPA_HS_WAIT);
    wire cond_fail   = issue && !cond_pass;
    wire exe_absent  = (hse_code_reg == CPA_HS_ABSENT);
    wire exe_done    = (hse_code_reg == CPA_HS_LAST) || (hse_code_reg == CPA_HS_GO);
    wire enter_vec   = (state_reg == CPA_ABS_DEC) || ((state_reg == CPA_EXE_WAIT) && exe_absent);

    always_comb begin
        state_next = state_reg;
        addr_next  = pc_in;
        nreq_next  = 1'b1;
        seq_next   = 1'b0;
        pass_next  = 1'b0;
        case (state_reg)
            CPA_IDLE: begin
                if (cond_fail) begin
                    nreq_next = 1'b0;
                    seq_next  = 1'b1;
                end else if (dec_absent || cp_undef) begin
                    state_next = CPA_ABS_DEC;
                    pass_next  = 1'b1;
                end else if (dec_wait) begin
                    state_next = CPA_EXE_WAIT;
                    pass_next  = 1'b1;
                end else if (issue) begin
                    nreq_next = 1'b0;
                    seq_next  = 1'b1;
                end
            end
            CPA_ABS_DEC: begin
                state_next = CPA_VEC0;
            end
            CPA_EXE_WAIT: begin
                // pass stays low after the first wait cycle
                if (exe_absent) begin
                    state_next = CPA_VEC0;
                end else if (exe_done) begin
                    state_next = CPA_IDLE;
                end
            end
            CPA_VEC0: begin
                state_next = CPA_VEC1;
            end
            CPA_VEC1: begin
                state_next = CPA_VEC2;
            end
            CPA_VEC2: begin
                state_next = CPA_IDLE;
            end
            default: begin
                state_next = CPA_IDLE;
            end
        endcase
        if (enter_vec) begin
            addr_next = CPA_UNDEF_VEC;
            nreq_next = 1'b0;
        end else if (state_next == CPA_VEC1 || state_next == CPA_VEC2) begin
            addr_next = addr_reg + CPA_WORD_STEP;
            nreq_next = 1'b0;
            seq_next  = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= CPA_IDLE;
            addr_reg  <= CPA_PC_RESET;
            nreq_reg  <= 1'b1;
            seq_reg   <= 1'b0;
            pass_reg  <= 1'b0;
            undef_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            addr_reg  <= addr_next;
            nreq_reg  <= nreq_next;
            seq_reg   <= seq_next;
            pass_reg  <= pass_next;
            undef_reg <= enter_vec;
        end
    end

    assign fetch_addr            = addr_reg;
    assign fetch_req_n           = nreq_reg;
    assign fetch_sequential      = seq_reg;
    assign pass_flag             = pass_reg;
    // this block never drives data transfers or a late cancel
    assign load_store_req_n      = 1'b1;
    assign load_store_sequential = 1'b0;
    assign load_store_addr       = 32'h0000_0000;
    assign late_abandon_flag     = 1'b0;
    assign seq_busy              = (state_reg != CPA_IDLE);
    assign undef_taken           = undef_reg;

    // AXI4-Lite slave: one write and one read at a time
    logic        aw_got_reg, w_got_reg, bvalid_reg, rvalid_reg;
    logic [3:0]  awaddr_reg;
    logic [31:0] wdata_reg, rdata_reg;
    logic [3:0]  wstrb_reg;
    logic [1:0]  bresp_reg, rresp_reg;

    wire aw_hs   = s_axi_awvalid && !aw_got_reg && !bvalid_reg;
    wire w_hs    = s_axi_wvalid && !w_got_reg && !bvalid_reg;
    wire wr_fire = aw_got_reg && w_got_reg;
    wire wr_ctrl = wr_fire && (awaddr_reg == CPA_OFS_CTRL);
    wire wr_ok   = (awaddr_reg == CPA_OFS_CTRL);
    wire ar_hs   = s_axi_arvalid && !rvalid_reg;
    // one-hot read select keeps the response mux flat
    wire sel_ctrl   = (s_axi_araddr == CPA_OFS_CTRL);
    wire sel_status = (s_axi_araddr == CPA_OFS_STATUS);
    wire sel_count  = (s_axi_araddr == CPA_OFS_COUNT);
    wire sel_pc     = (s_axi_araddr == CPA_OFS_PC);
    wire rd_ok      = sel_ctrl || sel_status || sel_count || sel_pc;
    wire clr_cnt = wr_ctrl && wstrb_reg[0] && wdata_reg[CPA_CTRL_CLRCNT_BIT];
    wire [31:0] status_word = {24'h00_0000, 2'h0, hse_code_reg, hsd_code_reg, seq_busy, pass_reg};
    wire [31:0] rd_word = sel_ctrl   ? ctrl_reg :
                          sel_status ? status_word :
                          sel_count  ? {skip_cnt_reg, undef_cnt_reg} :
                          sel_pc     ? last_word_reg : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            bvalid_reg <= 1'b0;
            awaddr_reg <= 4'h0;
            wdata_reg  <= 32'h0000_0000;
            wstrb_reg  <= 4'h0;
            bresp_reg  <= CPA_RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_reg <= 1'b0;
                w_got_reg  <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_ok ? CPA_RESP_OKAY : CPA_RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= CPA_RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= rd_ok ? CPA_RESP_OKAY : CPA_RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // only the wide bit of control is held on a write; clear bit self-clears
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= CPA_CTRL_RESET;
        end else if (wr_ctrl && wstrb_reg[0]) begin
            ctrl_reg <= {31'h0000_0000, wdata_reg[CPA_CTRL_WIDE_BIT]};
        end
    end

    // counters saturate-free wrap; event in the clearing cycle still counts
    always_ff @(posedge clk) begin
        if (rst) begin
            undef_cnt_reg <= 16'h0000;
            skip_cnt_reg  <= 16'h0000;
            last_word_reg <= 32'h0000_0000;
        end else begin
            undef_cnt_reg <= clr_cnt ? {15'h0000, enter_vec} : undef_cnt_reg + {15'h0000, enter_vec};
            skip_cnt_reg  <= clr_cnt ? {15'h0000, cond_fail} : skip_cnt_reg + {15'h0000, cond_fail};
            if (issue) begin
                last_word_reg <= fetched_word;
            end
        end
    end

    assign s_axi_awready = aw_hs;
    assign s_axi_wready  = w_hs;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = ar_hs;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
endmodule : cpa_seq
